// File: rtl/ccs_top.sv
// Behaviour
// - capture active: reads return shadow, not counter
// - interrupt once shadow refreshed by capture
// - one shared capture condition for both counters
// - counters wrap: overflow to zero, underflow max
// - edge field: off, rising, falling, both
// - source field: 1K, 32K, line three, two
// - interrupt on the third counter clock after a source edge
// - separate interrupt line per counter
// - capture detected separately for each counter
`include "ccs_cfg.svh"

module ccs_top import ccs_pkg::*; (
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         rstn,
  input  wire logic         ce,
  // configuration
  input  wire ccs_cfg_s     counter_config_two,
  // counter clocks and load
  input  wire ccs_cnt_clk_s clk_a,
  input  wire ccs_cnt_clk_s clk_b,
  input  wire ccs_load_s    load,
  // capture sources
  input  wire logic         src_1k,
  input  wire logic         src_32k,
  input  wire logic         port_a_line_two,
  input  wire logic         port_a_line_three,
  // processor view
  output logic        [7:0] counter_value_a,
  output logic        [7:0] counter_value_b,
  output logic              counter_a_irq,
  output logic              counter_b_irq
);

  logic [7:0] cnt_a;
  logic [7:0] cnt_b;
  logic [7:0] next_cnt_a;
  logic [7:0] next_cnt_b;
  logic [7:0] next_rd_a;
  logic [7:0] next_rd_b;
  logic [7:0] shadow_a;
  logic [7:0] shadow_b;
  logic       carry_a;
  logic       tick_b_eff;
  logic       down_b_eff;
  logic       cap_on;
  logic       sel_src;

  // one capture source shared by both counters
  always_comb begin
    case (counter_config_two.capture_source_select)
      `CCS_SRC_1K:  sel_src = src_1k;
      `CCS_SRC_32K: sel_src = src_32k;
      `CCS_SRC_PA3: sel_src = port_a_line_three;
      default:      sel_src = port_a_line_two;
    endcase
  end

  assign cap_on     = counter_config_two.capture_edge_select != `CCS_EDGE_OFF;
  // cascaded: counter b is the high byte, clocked by a's carry
  assign tick_b_eff = counter_config_two.cascade ? clk_a.tick : clk_b.tick;
  assign down_b_eff = counter_config_two.cascade ? counter_config_two.count_down_a
                                                 : counter_config_two.count_down_b;

  always_comb begin
    next_cnt_a = cnt_a;
    next_cnt_b = cnt_b;
    carry_a    = 1'b0;
    if (load.wr_a) begin
      next_cnt_a = load.data;
    end else if (clk_a.run && clk_a.tick) begin
      if (counter_config_two.count_down_a) begin
        next_cnt_a = cnt_a - `CCS_BYTE_STEP;
        carry_a    = cnt_a == `CCS_BYTE_ZERO;
      end else begin
        next_cnt_a = cnt_a + `CCS_BYTE_STEP;
        carry_a    = cnt_a == `CCS_BYTE_MAX;
      end
    end
    if (load.wr_b) begin
      next_cnt_b = load.data;
    end else if (counter_config_two.cascade ? carry_a : (clk_b.run && clk_b.tick)) begin
      next_cnt_b = down_b_eff ? cnt_b - `CCS_BYTE_STEP : cnt_b + `CCS_BYTE_STEP;
    end
    // reads see the shadows while capture is active
    next_rd_a = cap_on ? shadow_a : cnt_a;
    next_rd_b = cap_on ? shadow_b : cnt_b;
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      cnt_a           <= `CCS_BYTE_RST;
      cnt_b           <= `CCS_BYTE_RST;
      counter_value_a <= `CCS_BYTE_RST;
      counter_value_b <= `CCS_BYTE_RST;
    end else if (ce) begin
      cnt_a           <= next_cnt_a;
      cnt_b           <= next_cnt_b;
      counter_value_a <= next_rd_a;
      counter_value_b <= next_rd_b;
    end
  end

  // independent detection and interrupt per counter
  ccs_capture_lane lane_a (
    .mclk     (mclk),
    .rstn     (rstn),
    .ce       (ce),
    .tick     (clk_a.tick),
    .src      (sel_src),
    .edge_sel (counter_config_two.capture_edge_select),
    .count    (cnt_a),
    .shadow   (shadow_a),
    .irq      (counter_a_irq)
  );

  ccs_capture_lane lane_b (
    .mclk     (mclk),
    .rstn     (rstn),
    .ce       (ce),
    .tick     (tick_b_eff),
    .src      (sel_src),
    .edge_sel (counter_config_two.capture_edge_select),
    .count    (cnt_b),
    .shadow   (shadow_b),
    .irq      (counter_b_irq)
  );

  default clocking tcb @(posedge mclk); endclocking
  default disable iff (!rstn);

  shadow_read_a: assert property (ce && cap_on |=> counter_value_a == $past(shadow_a))
    else $error("read a does not show shadow");
  live_read_b: assert property (ce && !cap_on |=> counter_value_b == $past(cnt_b))
    else $error("read b does not show live counter");
  up_wrap_a: assert property (ce && clk_a.run && clk_a.tick && !load.wr_a
    && !counter_config_two.count_down_a && cnt_a == `CCS_BYTE_MAX |=> cnt_a == `CCS_BYTE_ZERO)
    else $error("counter a did not wrap to zero");
  down_wrap_casc_a: assert property (ce && counter_config_two.cascade && clk_a.run && clk_a.tick
    && !load.wr_a && !load.wr_b && counter_config_two.count_down_a
    && cnt_a == `CCS_BYTE_ZERO && cnt_b == `CCS_BYTE_ZERO
    |=> cnt_a == `CCS_BYTE_MAX && cnt_b == `CCS_BYTE_MAX)
    else $error("cascaded counter did not wrap to maximum");
  source_1k_a: assert property (counter_config_two.capture_source_select == `CCS_SRC_1K
    |-> sel_src == src_1k) else $error("1k source not selected");
  source_pa2_a: assert property (counter_config_two.capture_source_select == `CCS_SRC_PA2
    |-> sel_src == port_a_line_two) else $error("line two not selected");

  irq_a_c: cover property (counter_a_irq);
  irq_both_c: cover property (counter_a_irq && counter_b_irq && counter_config_two.cascade);
  split_irq_c: cover property (counter_b_irq && !counter_a_irq && !counter_config_two.cascade);

endmodule

// File: rtl/ccs_cfg.svh
`ifndef CCS_CFG_SVH
`define CCS_CFG_SVH

// capture edge field
`define CCS_EDGE_OFF  2'h0
`define CCS_EDGE_RISE 2'h1
`define CCS_EDGE_FALL 2'h2
`define CCS_EDGE_BOTH 2'h3

// capture source field
`define CCS_SRC_PA2   2'h0
`define CCS_SRC_PA3   2'h1
`define CCS_SRC_32K   2'h2
`define CCS_SRC_1K    2'h3

// counter byte values
`define CCS_BYTE_ZERO 8'h00
`define CCS_BYTE_MAX  8'hFF
`define CCS_BYTE_STEP 8'h01
`define CCS_BYTE_RST  8'h00

`endif

// File: rtl/ccs_pkg.sv
package ccs_pkg;

  typedef struct packed {
    logic [1:0] capture_edge_select;
    logic [1:0] capture_source_select;
    logic       cascade;
    logic       count_down_a;
    logic       count_down_b;
  } ccs_cfg_s;

  typedef struct packed {
    logic run;
    logic tick;
  } ccs_cnt_clk_s;

  typedef struct packed {
    logic       wr_a;
    logic       wr_b;
    logic [7:0] data;
  } ccs_load_s;

endpackage

// File: rtl/ccs_capture_lane.sv
`include "ccs_cfg.svh"

module ccs_capture_lane import ccs_pkg::*; (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rstn,
  input  wire logic       ce,
  // counter clock and capture source
  input  wire logic       tick,
  input  wire logic       src,
  input  wire logic [1:0] edge_sel,
  input  wire logic [7:0] count,
  // shadow and event
  output logic      [7:0] shadow,
  output logic            irq
);

  logic       s1;
  logic       s2;
  logic       s3;
  logic       hit;
  logic       next_s1;
  logic       next_s2;
  logic       next_s3;
  logic [7:0] next_shadow;
  logic       next_irq;

  // source resynchronised on the tick this lane is given (counter a's tick for b when cascaded), edge taken from the later stages
  always_comb begin
    next_s1     = s1;
    next_s2     = s2;
    next_s3     = s3;
    next_shadow = shadow;
    next_irq    = 1'b0;
    hit         = 1'b0;
    if (tick) begin
      next_s1 = src;
      next_s2 = s1;
      next_s3 = s2;
      case (edge_sel)
        `CCS_EDGE_RISE: hit = s2 & ~s3;
        `CCS_EDGE_FALL: hit = ~s2 & s3;
        `CCS_EDGE_BOTH: hit = s2 ^ s3;
        default:        hit = 1'b0;
      endcase
      if (hit) begin
        next_shadow = count;
        next_irq    = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      s1     <= 1'b0;
      s2     <= 1'b0;
      s3     <= 1'b0;
      shadow <= `CCS_BYTE_RST;
      irq    <= 1'b0;
    end else if (ce) begin
      s1     <= next_s1;
      s2     <= next_s2;
      s3     <= next_s3;
      shadow <= next_shadow;
      irq    <= next_irq;
    end
  end

  default clocking lcb @(posedge mclk); endclocking
  default disable iff (!rstn);

  rise_capture_a: assert property (ce && tick && edge_sel == `CCS_EDGE_RISE && s2 && !s3
    |=> irq && shadow == $past(count)) else $error("rising edge not captured");
  fall_capture_a: assert property (ce && tick && edge_sel == `CCS_EDGE_FALL && !s2 && s3
    |=> irq && shadow == $past(count)) else $error("falling edge not captured");
  capture_off_a: assert property (ce && edge_sel == `CCS_EDGE_OFF
    |=> !irq && $stable(shadow)) else $error("capture while disabled");
  irq_after_sync_a: assert property (ce && tick && edge_sel == `CCS_EDGE_BOTH && s2 != s3
    |=> irq && shadow == $past(count)) else $error("interrupt missing after synchronised edge");
  irq_source_a: assert property (irq |-> $past(tick) && $past(s2) != $past(s3))
    else $error("interrupt without detected edge");

  both_edge_c: cover property (ce && tick && edge_sel == `CCS_EDGE_BOTH && s2 != s3);

endmodule

// File: bench/ccs_cpu_model.sv
module ccs_cpu_model import ccs_pkg::*; (
  // clock
  input  wire logic       mclk,
  // reads and interrupts
  input  wire logic [7:0] counter_value_a,
  input  wire logic [7:0] counter_value_b,
  input  wire logic       counter_a_irq,
  input  wire logic       counter_b_irq,
  // what software saw
  output logic      [7:0] shadow_a,
  output logic      [7:0] shadow_b,
  output int              n_a,
  output int              n_b
);
  timeunit 1ns;
  timeprecision 1ns;
  logic seen_a = 0;
  logic seen_b = 0;
  initial begin
    shadow_a = 8'h00;
    shadow_b = 8'h00;
    n_a = 0;
    n_b = 0;
  end
  // a shadow is read only after its own interrupt, once the read path has caught up
  always @(posedge mclk) begin
    seen_a <= counter_a_irq;
    seen_b <= counter_b_irq;
    if (seen_a === 1'b1) shadow_a <= counter_value_a;
    if (seen_b === 1'b1) shadow_b <= counter_value_b;
    if (counter_a_irq === 1'b1) n_a <= n_a + 1;
    if (counter_b_irq === 1'b1) n_b <= n_b + 1;
  end
endmodule

// File: bench/tb_counter_capture_shadow.sv
module tb_counter_capture_shadow import ccs_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic         mclk = 0;
  logic         rstn = 0;
  logic         ce = 1;
  logic         noise = 0;
  ccs_cfg_s     cfg;
  ccs_cnt_clk_s clk_a;
  ccs_cnt_clk_s clk_b;
  ccs_load_s    load;
  logic [3:0]   src;
  logic [7:0]   val_a, val_b, sh_a, sh_b, d, pa, pb;
  logic         irq_a, irq_b, dn, cs, had;
  logic [31:0]  rng = 32'h98C5EEEC;
  logic [31:0]  r, r2;
  int           n_a, n_b, n, expn, first, per, ba, bb;
  bit           hit;
  logic         slow_b = 0;
  logic [15:0]  exp16;
  int           err_count = 0;
  int           samples_checked = 0;
  int           cycles = 0;

  // source index equals the select code
  ccs_top dut (.mclk(mclk), .rstn(rstn), .ce(ce), .counter_config_two(cfg), .clk_a(clk_a), .clk_b(clk_b),
    .load(load), .src_1k(src[3]), .src_32k(src[2]), .port_a_line_two(src[0]), .port_a_line_three(src[1]),
    .counter_value_a(val_a), .counter_value_b(val_b), .counter_a_irq(irq_a), .counter_b_irq(irq_b));
  ccs_cpu_model cpu (.mclk(mclk), .counter_value_a(val_a), .counter_value_b(val_b), .counter_a_irq(irq_a),
    .counter_b_irq(irq_b), .shadow_a(sh_a), .shadow_b(sh_b), .n_a(n_a), .n_b(n_b));

  always #50 mclk = ~mclk;

  function automatic logic [31:0] nxt();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction

  function automatic logic [15:0] exp_live(logic [7:0] v, int k, logic down, logic casc);
    logic [15:0] s;
    s = down ? 16'(-k) : 16'(k);
    if (casc) return {v, v} + s;
    return {v + s[7:0], v + s[7:0]};
  endfunction

  task chk_val(input logic [15:0] got, input logic [15:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task chk_cnt(input int got, input int exp, input string what);
    samples_checked++;
    if (got != exp) begin
      err_count++;
      $display("ERROR at %0t: %s got %0d expected %0d", $time, what, got, exp);
    end
  endtask

  task end_of_test;
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task step(input int k);
    repeat (k) @(negedge mclk);
  endtask

  task load_ab(input logic [7:0] v);
    load = '{wr_a: 1'b1, wr_b: 1'b1, data: v};
    step(1);
    load = '0;
  endtask

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 10000) begin
      err_count++;
      $display("ERROR at %0t: timeout", $time);
      end_of_test();
    end
  end

  // unselected sources toggle at random so a wrong selection shows up as extra captures
  always @(negedge mclk) if (noise) begin
    r2 = nxt();
    for (int i = 0; i < 4; i++) if (i != cfg.capture_source_select) src[i] <= r2[i];
  end

  // counter b ticks every other cycle in the falling-edge capture runs
  always @(negedge mclk) clk_b.tick <= slow_b ? ~clk_b.tick : 1'b1;

  initial begin
    cfg = '0;
    clk_a = '{run: 1'b0, tick: 1'b1};
    clk_b = clk_a;
    load = '0;
    src = '0;
    step(16);
    rstn = 1;
    step(2);
    chk_val({val_b, val_a}, 16'h0000, "reset reads");
    chk_cnt(n_a + n_b, 0, "reset irqs");
    // live counting, capture off: wrap corners first, then random
    for (int k = 0; k < 24; k++) begin
      r = nxt();
      d = (k == 0) ? 8'hFF : (k == 1) ? 8'h00 : r[7:0];
      dn = (k == 1) ? 1'b1 : (k == 0) ? 1'b0 : r[9];
      cs = (k < 2) ? 1'b1 : r[8];
      n = (k < 2) ? 1 : int'(r[15:10]) + 1;
      cfg.cascade = cs;
      cfg.count_down_a = dn;
      cfg.count_down_b = dn;
      step(1);
      load_ab(d);
      clk_a.run = 1;
      clk_b.run = 1;
      step(n);
      // clock enable low must freeze the counters although run is still set
      ce = 1'b0;
      step(int'(r[18:16]) + 1);
      ce = 1'b1;
      clk_a.run = 0;
      clk_b.run = 0;
      step(3);
      chk_val({val_b, val_a}, exp_live(d, n, dn, cs), "live count");
    end
    // capture: every source with every edge mode, a counts up, b down except in the cascaded runs
    cfg.count_down_a = 0;
    cfg.count_down_b = 1;
    for (int c = 0; c < 16; c++) begin
      noise = 0;
      clk_a.run = 0;
      clk_b.run = 0;
      step(4);
      src = '0;
      // rising-edge runs are cascaded, falling-edge runs give counter b a half-rate clock
      cfg.cascade = (c[1:0] == 2'h1);
      slow_b = (c[1:0] == 2'h2);
      cfg.capture_source_select = c[3:2];
      cfg.capture_edge_select = c[1:0];
      load_ab(8'hFF);
      step(4);
      ba = n_a;
      bb = n_b;
      expn = 0;
      had = 0;
      per = (c[1:0] == 2'h3) ? 8 : 16;
      noise = 1;
      clk_a.run = 1;
      clk_b.run = 1;
      for (int t = 0; t < 6; t++) begin
        src[c[3:2]] = ~src[c[3:2]];
        hit = (c[1:0] == 2'h3) || (c[1:0] == (src[c[3:2]] ? 2'h1 : 2'h2));
        expn += hit;
        first = 0;
        pa = sh_a;
        pb = sh_b;
        for (int i = 1; i <= 8; i++) begin
          step(1);
          if (irq_a === 1'b1 && first == 0) first = i;
        end
        chk_cnt(n_a - ba, expn, "irq a count");
        chk_cnt(n_b - bb, expn, "irq b count");
        if (hit) chk_cnt(int'(first >= 2 && first <= 5), 1, "irq delay");
        exp16 = cfg.cascade ? {pb, pa} + 16'(per) : {pb - 8'(slow_b ? per / 2 : per), pa + 8'(per)};
        if (hit && had) chk_val({sh_b, sh_a}, exp16, "shadow step");
        had = had | hit;
        if (had) chk_val({val_b, val_a}, {sh_b, sh_a}, "shadow read");
      end
    end
    end_of_test();
  end
endmodule
